// ===== sfp_ctrl.sv
`timescale 1ns/1ps
`include "sfp_regs.svh"
module sfp_ctrl
  import sfp_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID = 8'h5a, // Arbitrary value.
  parameter int RESET_RECOVERY_NS = 1000,
  parameter int SUSPEND_MAX_NS = 1000,
  parameter int RELEASE_TIME_NS = 1000,
  parameter int POWERDOWN_ENTRY_DELAY_NS = 1000
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Serial link.
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic [3:0] io_in,
  output logic so_out,
  output logic so_oe_out,
  // Mode bits from the status logic.
  input wire logic four_byte_address_flag_in,
  input wire logic quad_instruction_mode_in,
  // Array engine and security storage.
  input wire sfp_arr_in_s arr_in,
  output sfp_arr_out_s arr_out,
  output logic [31:0] sec_addr_out,
  input wire logic [7:0] sec_data_in,
  // Commands handed to the rest of the device.
  output logic cmd_valid_out,
  output logic [7:0] cmd_opcode_out,
  // Status.
  output logic write_in_progress_flag_out,
  output logic [1:0] suspend_flags_out,
  output logic deep_powerdown_out,
  output logic low_power_out,
  output logic cmd_blocked_out
);
  localparam int CK = `SFP_CLK_NS;
  localparam int RST_RAW = (RESET_RECOVERY_NS + CK - 1) / CK;
  localparam int RST_CYC = (RST_RAW < 1) ? 1 : RST_RAW;
  localparam int SUS_RAW = SUSPEND_MAX_NS / CK;
  localparam int SUS_CYC = (SUS_RAW < 1) ? 1 : SUS_RAW;
  localparam int REL_RAW = (RELEASE_TIME_NS + CK - 1) / CK;
  localparam int REL_CYC = (REL_RAW < 1) ? 1 : REL_RAW;
  localparam int PD_RAW = (POWERDOWN_ENTRY_DELAY_NS + CK - 1) / CK;
  localparam int PD_CYC = (PD_RAW < 1) ? 1 : PD_RAW;
  localparam int RES_RAW = `SFP_RESUME_MAX_NS / CK;
  localparam int RES_CYC = (RES_RAW < 1) ? 1 : RES_RAW;

  function automatic logic is_local(input logic [7:0] op);
    is_local = op inside {`SFP_OP_SEC_RD, `SFP_OP_RST_EN, `SFP_OP_RST, `SFP_OP_SUS,
                          `SFP_OP_RES, `SFP_OP_PWRDN, `SFP_OP_REL};
  endfunction

  // Opcodes that a suspended program or erase must not see.
  function automatic logic refused(input logic [7:0] op, input logic [1:0] sf);
    logic er;
    logic pg;
    logic wr;
    er = op inside {`SFP_OP_SE_A, `SFP_OP_SE_B, `SFP_OP_BK32_A, `SFP_OP_BK32_B,
                    `SFP_OP_BK64_A, `SFP_OP_BK64_B, `SFP_OP_CHIP_A, `SFP_OP_CHIP_B};
    pg = op inside {`SFP_OP_PG_A, `SFP_OP_PG_B, `SFP_OP_QPG_A, `SFP_OP_QPG_B, `SFP_OP_SEC_PG};
    wr = op inside {`SFP_OP_WRSR, `SFP_OP_SEC_ER};
    refused = (sf[0] && (er || pg || wr)) || (sf[1] && (er || wr)); // R10 R11
  endfunction

  sfp_st_s st_r;
  sfp_st_s st_nxt;
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;
  logic sel;
  logic quad;
  logic exact;
  logic frame_ok;
  logic rst_go;
  logic sus_go;
  logic res_go;
  logic pd_go;
  logic rel_go;
  logic [5:0] step;
  logic [5:0] alen;
  logic [7:0] nopc;
  logic [7:0] obyte;

  // First synchroniser stages are never read; select is kept active high so reset matches an idle link.
  assign rise = st_r.sck_s & ~st_r.sck_p; // R1
  assign fall = ~st_r.sck_s & st_r.sck_p; // R2
  assign cs_fall = st_r.cs_s & ~st_r.cs_p;
  assign cs_rise = ~st_r.cs_s & st_r.cs_p;
  assign sel = st_r.cs_s;
  assign quad = quad_instruction_mode_in;
  assign step = quad ? `SFP_NIB : `SFP_ONE_BIT; // R4
  assign nopc = quad ? {st_r.opc[3:0], st_r.io_s} : {st_r.opc[6:0], st_r.io_s[0]};
  assign alen = four_byte_address_flag_in ? `SFP_ADDR4_BITS : `SFP_ADDR3_BITS; // R21
  assign obyte = (st_r.ph == PH_SDATA) ? sec_data_in : DEVICE_ID;
  // Decisions made when select rises; short frames never qualify.
  assign exact = st_r.opc_ok & ~st_r.extra; // R14
  assign frame_ok = cs_rise & st_r.opc_ok & ~st_r.blk; // R6 R23
  assign rst_go = frame_ok & exact & (st_r.opc == `SFP_OP_RST) & st_r.rst_en; // R4
  assign sus_go = frame_ok & exact & (st_r.opc == `SFP_OP_SUS) & ~st_r.pdn & st_r.inprog
                  & (st_r.susf == 2'h0) & (st_r.tk == TM_NONE)
                  & ((st_r.kind == `SFP_KIND_PROG) | (st_r.kind == `SFP_KIND_ERASE)); // R8
  assign res_go = frame_ok & exact & (st_r.opc == `SFP_OP_RES) & ~st_r.pdn
                  & (st_r.susf != 2'h0) & ~st_r.inprog; // R12
  assign pd_go = frame_ok & exact & (st_r.opc == `SFP_OP_PWRDN) & ~st_r.pdn
                 & ~st_r.inprog & (st_r.tk == TM_NONE); // R14 R15
  assign rel_go = frame_ok & (st_r.opc == `SFP_OP_REL) & st_r.pdn & ~st_r.inprog; // R16 R20

  always_comb begin
    st_nxt = st_r;
    st_nxt.sck_m = sck_in;
    st_nxt.sck_s = st_r.sck_m;
    st_nxt.sck_p = st_r.sck_s;
    st_nxt.cs_m = ~cs_n_in;
    st_nxt.cs_s = st_r.cs_m;
    st_nxt.cs_p = st_r.cs_s;
    st_nxt.io_m = io_in;
    st_nxt.io_s = st_r.io_m;
    st_nxt.fwd = 1'b0;
    st_nxt.arr = '0;
    if (cs_fall) begin
      st_nxt.ph = PH_OPC;
      st_nxt.cnt = '0;
      st_nxt.sh = '0;
      st_nxt.opc_ok = 1'b0;
      st_nxt.extra = 1'b0;
    end else if (sel && rise) begin
      unique case (st_r.ph)
        PH_OPC: begin
          st_nxt.opc = nopc;
          st_nxt.cnt = st_r.cnt + step;
          if (st_nxt.cnt == `SFP_OP_BITS) begin
            st_nxt.opc_ok = 1'b1;
            st_nxt.cnt = '0;
            st_nxt.ph = PH_DROP;
            if (!st_r.blk && !quad) begin
              if (nopc == `SFP_OP_SEC_RD && !st_r.pdn) begin
                st_nxt.ph = PH_ADDR; // R1 R16
              end
              if (nopc == `SFP_OP_REL && !st_r.inprog) begin
                st_nxt.ph = PH_IDUMMY; // R19 R20
              end
            end
            if (!st_r.blk && !st_r.pdn && !is_local(nopc) && !refused(nopc, st_r.susf)) begin
              st_nxt.fwd = 1'b1; // R6 R10 R11 R16
              st_nxt.fopc = nopc;
            end
          end
        end
        PH_ADDR: begin
          st_nxt.sh = {st_r.sh[30:0], st_r.io_s[0]};
          st_nxt.cnt = st_r.cnt + `SFP_ONE_BIT;
          if (st_nxt.cnt == alen) begin
            st_nxt.addr = st_nxt.sh; // R21
            st_nxt.cnt = '0;
            st_nxt.ph = PH_DUMMY;
          end
        end
        PH_DUMMY: begin
          st_nxt.cnt = st_r.cnt + `SFP_ONE_BIT;
          if (st_nxt.cnt == `SFP_DUMMY_BITS) begin
            st_nxt.ph = PH_SDATA; // R1
            st_nxt.obit = '0;
          end
        end
        PH_IDUMMY: begin
          st_nxt.cnt = st_r.cnt + `SFP_ONE_BIT;
          if (st_nxt.cnt == `SFP_ID_DUMMY_BITS) begin
            st_nxt.ph = PH_IDATA; // R19
            st_nxt.obit = '0;
          end
        end
        PH_SDATA, PH_IDATA, PH_DROP, PH_IDLE: begin
          st_nxt.extra = 1'b1;
        end
      endcase
    end else if (sel && fall && (st_r.ph == PH_SDATA || st_r.ph == PH_IDATA)) begin
      st_nxt.so_oe = 1'b1;
      st_nxt.obit = st_r.obit + 3'h1;
      if (st_r.obit == 3'h0) begin
        st_nxt.so = obyte[7]; // R2 R19
        st_nxt.ob = {obyte[6:0], 1'b0};
        if (st_r.ph == PH_SDATA) begin
          st_nxt.addr[9:0] = (st_r.addr[9:0] == `SFP_SEC_LAST) ? `SFP_SEC_FIRST
                                                                : st_r.addr[9:0] + 10'h001; // R3
        end
      end else begin
        st_nxt.so = st_r.ob[7]; // R2
        st_nxt.ob = {st_r.ob[6:0], 1'b0};
      end
    end
    if (cs_rise) begin
      st_nxt.ph = PH_IDLE;
      st_nxt.so_oe = 1'b0;
    end
    if (frame_ok) begin
      st_nxt.rst_en = exact && (st_r.opc == `SFP_OP_RST_EN); // R4
    end
    // Array cycle tracking.
    if (arr_in.start && !st_r.inprog) begin
      st_nxt.inprog = 1'b1; // R22
      st_nxt.kind = arr_in.kind;
    end
    if (arr_in.done && st_r.inprog && st_r.tk != TM_SUS) begin
      st_nxt.inprog = 1'b0; // R22
    end
    if (st_r.tk != TM_NONE) begin
      if (st_r.tmr <= 20'h00001) begin
        st_nxt.tk = TM_NONE;
        if (st_r.tk == TM_SUS) begin
          st_nxt.inprog = 1'b0; // R9
        end
        if (st_r.tk == TM_PD) begin
          st_nxt.lowp = 1'b1; // R14
        end
      end else begin
        st_nxt.tmr = st_r.tmr - 20'h00001;
      end
    end
    if (sus_go) begin
      st_nxt.susf = st_r.kind; // R9
      st_nxt.arr.sus_req = 1'b1;
      st_nxt.tk = TM_SUS;
      st_nxt.tmr = 20'(SUS_CYC);
    end
    if (res_go) begin
      st_nxt.susf = 2'h0; // R13
      st_nxt.inprog = 1'b1;
      st_nxt.kind = st_r.susf;
      st_nxt.arr.res_req = 1'b1;
    end
    if (pd_go) begin
      st_nxt.pdn = 1'b1; // R14
      st_nxt.tk = TM_PD;
      st_nxt.tmr = 20'(PD_CYC);
    end
    if (rel_go) begin
      st_nxt.pdn = 1'b0; // R17
      st_nxt.lowp = 1'b0;
      st_nxt.tk = TM_REL;
      st_nxt.tmr = 20'(REL_CYC);
    end
    if (rst_go) begin
      st_nxt.inprog = 1'b0; // R5
      st_nxt.susf = 2'h0;
      st_nxt.kind = 2'h0;
      st_nxt.pdn = 1'b0;
      st_nxt.lowp = 1'b0;
      st_nxt.rst_en = 1'b0;
      st_nxt.arr.abort = 1'b1;
      st_nxt.arr.vol_clr = 1'b1;
      st_nxt.tk = TM_RST; // R6
      st_nxt.tmr = 20'(RST_CYC);
    end
    st_nxt.blk = (st_nxt.tk == TM_RST) || (st_nxt.tk == TM_REL); // R6 R17
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign so_out = st_r.so;
  assign so_oe_out = st_r.so_oe;
  assign arr_out = st_r.arr;
  assign sec_addr_out = st_r.addr;
  assign cmd_valid_out = st_r.fwd;
  assign cmd_opcode_out = st_r.fopc;
  assign write_in_progress_flag_out = st_r.inprog;
  assign suspend_flags_out = st_r.susf;
  assign deep_powerdown_out = st_r.pdn;
  assign low_power_out = st_r.lowp;
  assign cmd_blocked_out = st_r.blk;

  a_reset_clears: assert property ( // R5
    @(posedge clk_in) disable iff (!rst_n_in)
    st_r.arr.abort |-> !st_r.inprog && st_r.susf == 2'h0 && !st_r.pdn && st_r.blk)
    else $error("reset did not clear state");
  a_recover_hold: assert property ( // R6
    @(posedge clk_in) disable iff (!rst_n_in)
    st_r.arr.abort |-> (!st_r.fwd && !st_r.arr.sus_req && !st_r.arr.res_req) [*8])
    else $error("command taken during reset recovery");
  a_recover_len: assert property ( // R6
    @(posedge clk_in) disable iff (!rst_n_in)
    st_r.arr.abort |-> ##RST_CYC (st_r.tk != TM_RST))
    else $error("reset recovery length wrong");
  a_suspend_gate: assert property ( // R8
    @(posedge clk_in) disable iff (!rst_n_in)
    st_r.arr.sus_req |-> $past(st_r.inprog) && $past(st_r.susf) == 2'h0 && $past(st_r.kind) != 2'h0)
    else $error("suspend taken without running cycle");
  a_suspend_done: assert property ( // R9
    @(posedge clk_in) disable iff (!rst_n_in)
    st_r.arr.sus_req |-> st_r.susf != 2'h0 ##[1:SUS_CYC] !st_r.inprog)
    else $error("suspend did not settle in time");
  a_resume_gate: assert property ( // R12
    @(posedge clk_in) disable iff (!rst_n_in)
    st_r.arr.res_req |-> $past(st_r.susf) != 2'h0 && !$past(st_r.inprog))
    else $error("resume taken while not suspended");
  a_resume_busy: assert property ( // R13
    @(posedge clk_in) disable iff (!rst_n_in)
    $fell(st_r.susf != 2'h0) && !st_r.arr.abort |-> ##[0:RES_CYC] st_r.inprog)
    else $error("resume did not set busy in time");
  a_pd_busy: assert property ( // R15
    @(posedge clk_in) disable iff (!rst_n_in)
    $rose(st_r.pdn) |-> !$past(st_r.inprog) && st_r.tk == TM_PD)
    else $error("power-down taken while busy");
  a_pd_quiet: assert property ( // R16
    @(posedge clk_in) disable iff (!rst_n_in)
    st_r.fwd |-> !$past(st_r.pdn) && !$past(st_r.blk))
    else $error("command passed in power-down or recovery");
  a_release_wait: assert property ( // R17
    @(posedge clk_in) disable iff (!rst_n_in)
    $fell(st_r.pdn) && !st_r.arr.abort |-> st_r.blk [*8])
    else $error("release time not kept");
  a_suspend_refuse: assert property ( // R10
    @(posedge clk_in) disable iff (!rst_n_in)
    st_r.fwd |-> !refused(st_r.fopc, $past(st_r.susf)))
    else $error("refused opcode passed while suspended");
  a_addr_wrap: assert property ( // R3
    @(posedge clk_in) disable iff (!rst_n_in)
    sel && fall && st_r.ph == PH_SDATA && st_r.obit == 3'h0 |=> st_r.addr[9:0] != $past(st_r.addr[9:0])
    && st_r.addr[31:10] == $past(st_r.addr[31:10]))
    else $error("security address did not advance");
  a_out_falling: assert property ( // R2
    @(posedge clk_in) disable iff (!rst_n_in)
    $changed(st_r.so) |-> $past(fall))
    else $error("output bit changed off a falling edge");
  a_short_frame: assert property ( // R23
    @(posedge clk_in) disable iff (!rst_n_in)
    cs_rise && !st_r.opc_ok |=> st_r.rst_en == $past(st_r.rst_en) && st_r.pdn == $past(st_r.pdn))
    else $error("short frame changed state");
endmodule // sfp_ctrl

// ===== sfp_ctrl_test.sv
`timescale 1ns/1ps
module sfp_ctrl_test;
  import sfp_pkg::*;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary value.
  logic clk = 1'b0, rst_n = 1'b0, four_b = 1'b0, quad = 1'b0;
  sfp_arr_in_s arr = '0;
  sfp_arr_out_s arr_o;
  wire cs_n, sck, so, so_oe;
  wire [3:0] io;
  logic [31:0] sec_addr, rx;
  logic [7:0] sec_data, cmd_op;
  logic cmd_valid, write_in_progress_flag, deep, lowp, blk;
  logic [1:0] sus;
  int mismatches = 0, total_checks = 0, fwd_cnt = 0, oe_cnt = 0, abort_cnt = 0, clr_cnt = 0;
  int sus_cnt = 0, res_cnt = 0;
  logic [7:0] ops [15] = '{8'h01, 8'h44, 8'h20, 8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc, 8'hc7, 8'h60,
                           8'h42, 8'h02, 8'h12, 8'h32, 8'h34};

  function automatic logic [7:0] exp_sec(input logic [9:0] a);
    return a[7:0] ^ {6'h00, a[9:8]} ^ 8'h5c;
  endfunction
  assign sec_data = exp_sec(sec_addr[9:0]);

  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) fwd_cnt <= fwd_cnt + 1;
    if (so_oe === 1'b1) oe_cnt <= oe_cnt + 1;
    if (arr_o.abort === 1'b1) abort_cnt <= abort_cnt + 1;
    if (arr_o.vol_clr === 1'b1) clr_cnt <= clr_cnt + 1;
    if (arr_o.sus_req === 1'b1) sus_cnt <= sus_cnt + 1;
    if (arr_o.res_req === 1'b1) res_cnt <= res_cnt + 1;
  end

  sfp_ctrl #(.DEVICE_ID(ID), .RESET_RECOVERY_NS(4000), .SUSPEND_MAX_NS(200), .RELEASE_TIME_NS(200),
    .POWERDOWN_ENTRY_DELAY_NS(200)) dut (
    .clk_in(clk), .rst_n_in(rst_n), .cs_n_in(cs_n), .sck_in(sck), .io_in(io), .so_out(so),
    .so_oe_out(so_oe), .four_byte_address_flag_in(four_b), .quad_instruction_mode_in(quad),
    .arr_in(arr), .arr_out(arr_o), .sec_addr_out(sec_addr), .sec_data_in(sec_data),
    .cmd_valid_out(cmd_valid), .cmd_opcode_out(cmd_op), .write_in_progress_flag_out(write_in_progress_flag),
    .suspend_flags_out(sus), .deep_powerdown_out(deep), .low_power_out(lowp), .cmd_blocked_out(blk));

  sfp_host host (.clk_in(clk), .cs_n_out(cs_n), .sck_out(sck), .io_out(io), .so_in(so), .quad_in(quad));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic arr_pulse(input logic s, input logic [1:0] k, input logic d);
    @(posedge clk);
    #1 arr = '{start: s, kind: k, done: d};
    @(posedge clk);
    #1 arr = '0;
    repeat (2) @(posedge clk);
  endtask

  task automatic cmd(input logic [7:0] op);
    host.xfer({op, 56'h0}, quad ? 2 : 8, 0, 400, rx);
  endtask

  task automatic fwd(input logic [7:0] op, input int n, input int exp);
    int c;
    c = fwd_cnt;
    host.xfer({op, 56'h0}, n, 0, 400, rx);
    chk("forwarded", exp, fwd_cnt - c);
  endtask

  task automatic t_sec;
    host.xfer({8'h48, 24'h0023fe, 8'h00, 24'h0}, 40, 24, 400, rx);
    chk("sec bytes", {8'h00, exp_sec(10'h3fe), exp_sec(10'h3ff), exp_sec(10'h000)}, rx);
    chk("sec upper", 32'h00002000, sec_addr & 32'hfffffc00);
    @(posedge clk);
    #1 four_b = 1'b1;
    host.xfer({8'h48, 32'h000013ff, 8'h00, 16'h0}, 48, 16, 400, rx);
    chk("sec4 bytes", {16'h0, exp_sec(10'h3ff), exp_sec(10'h000)}, rx);
    @(posedge clk);
    #1 four_b = 1'b0;
  endtask

  task automatic t_id;
    int c;
    c = oe_cnt;
    host.xfer({8'hab, 56'h0}, 32, 16, 400, rx);
    chk("id", {16'h0, ID, ID}, rx);
    chk("id drive", 1, oe_cnt > c);
    arr_pulse(1'b1, 2'h3, 1'b0);
    c = oe_cnt;
    host.xfer({8'hab, 56'h0}, 32, 16, 400, rx);
    chk("id while busy", 0, oe_cnt - c);
    chk("busy kept", 1, write_in_progress_flag);
    arr_pulse(1'b0, 2'h0, 1'b1);
  endtask

  task automatic t_susp;
    for (int k = 1; k <= 2; k++) begin
      cmd(8'h75);
      chk("idle suspend", 0, sus);
      arr_pulse(1'b1, k[1:0], 1'b0);
      chk("busy", 1, write_in_progress_flag);
      cmd(8'h75);
      chk("suspend", k, sus);
      chk("busy after suspend", 0, write_in_progress_flag);
      cmd(8'h75);
      chk("second suspend", k, sus);
      for (int i = 0; i < 15; i++) fwd(ops[i], 8, (k == 2 && i >= 10) ? 1 : 0);
      cmd(8'h7a);
      chk("resume flags", 0, sus);
      chk("resume busy", 1, write_in_progress_flag);
      arr_pulse(1'b0, 2'h0, 1'b1);
      chk("done", 0, write_in_progress_flag);
      cmd(8'h7a);
      chk("idle resume", 0, {sus, write_in_progress_flag});
    end
    chk("suspend pulses", 2, sus_cnt);
    chk("resume pulses", 2, res_cnt);
  endtask

  task automatic t_pd;
    arr_pulse(1'b1, 2'h1, 1'b0);
    cmd(8'hb9);
    chk("pd while busy", 2'b01, {deep, write_in_progress_flag});
    arr_pulse(1'b0, 2'h0, 1'b1);
    host.xfer({8'hb9, 56'h0}, 9, 0, 400, rx);
    chk("pd long frame", 0, deep);
    cmd(8'hb9);
    chk("pd entered", 2'b11, {deep, lowp});
    fwd(8'h03, 8, 0);
    cmd(8'hab);
    chk("released", 3'b000, {deep, lowp, blk});
    fwd(8'h03, 8, 1);
    fwd(8'h03, 4, 0);
  endtask

  task automatic t_reset;
    int a;
    int v;
    arr_pulse(1'b1, 2'h2, 1'b0);
    cmd(8'h75);
    cmd(8'hb9);
    chk("poll before reset", 3'b100, {sus, write_in_progress_flag});
    chk("pd before reset", 1, deep);
    @(posedge clk);
    #1 quad = 1'b1;
    a = abort_cnt;
    v = clr_cnt;
    cmd(8'h66);
    cmd(8'h99);
    chk("reset state", 5'b10000, {blk, sus, write_in_progress_flag, deep});
    chk("abort pulses", 1, abort_cnt - a);
    chk("clear pulses", 1, clr_cnt - v);
    @(posedge clk);
    #1 quad = 1'b0;
    fwd(8'h03, 8, 0);
    repeat (200) @(posedge clk);
    fwd(8'h03, 8, 1);
    chk("opcode", 8'h03, cmd_op);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #1000000;
    mismatches++;
    print_verdict;
  end

  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (5) @(posedge clk);
    t_sec;
    t_id;
    t_susp;
    t_pd;
    t_reset;
    print_verdict;
  end
endmodule // sfp_ctrl_test

// ===== sfp_host.sv
`timescale 1ns/1ps
module sfp_host (
  // Bench clock, used only to place frame starts off its edges.
  input wire logic clk_in,
  // Serial link to the device.
  output logic cs_n_out,
  output logic sck_out,
  output logic [3:0] io_out,
  input wire logic so_in,
  // Opcode width mode.
  input wire logic quad_in
);
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    io_out = 4'h5;
  end

  // Clock runs only inside a frame; data changes while it is low and is taken on the rise.
  // Read data is sampled at the end of the high phase, long after the falling edge launched it.
  task automatic xfer(input logic [63:0] tx, input int ntx, input int nrx, input int gap,
                      output logic [31:0] rx);
    int i;
    begin
      rx = '0;
      // Every pin change then lands one step after a clock edge, never on it.
      @(posedge clk_in);
      #1 cs_n_out = 1'b0;
      #200;
      for (i = 0; i < ntx + nrx; i++) begin
        if (quad_in && i < 2) io_out = tx[63-4*i -: 4];
        else if (i < ntx) io_out = {~io_out[3:1], tx[63-i]};
        else io_out = ~io_out;
        #80 sck_out = 1'b1;
        #80;
        if (i >= ntx) rx = {rx[30:0], so_in};
        sck_out = 1'b0;
      end
      #80 cs_n_out = 1'b1;
      io_out = ~io_out;
      // Select stays high between frames for gap ns, covering release times shorter than that.
      #gap;
    end
  endtask
endmodule // sfp_host

// ===== sfp_pkg.sv
package sfp_pkg;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_OPC = 3'b001,
    PH_ADDR = 3'b010,
    PH_DUMMY = 3'b011,
    PH_SDATA = 3'b100,
    PH_IDUMMY = 3'b101,
    PH_IDATA = 3'b110,
    PH_DROP = 3'b111
  } sfp_phase_e;
  typedef enum logic [2:0] {
    TM_NONE = 3'b000,
    TM_RST = 3'b001,
    TM_SUS = 3'b010,
    TM_PD = 3'b011,
    TM_REL = 3'b100
  } sfp_tmr_e;
  typedef struct packed {
    logic start;
    logic [1:0] kind;
    logic done;
  } sfp_arr_in_s;
  typedef struct packed {
    logic sus_req;
    logic res_req;
    logic abort;
    logic vol_clr;
  } sfp_arr_out_s;
  typedef struct packed {
    logic sck_m, sck_s, sck_p;
    logic cs_m, cs_s, cs_p;
    logic [3:0] io_m, io_s;
    sfp_phase_e ph;
    logic [5:0] cnt;
    logic [7:0] opc;
    logic opc_ok, extra;
    logic [31:0] sh, addr;
    logic [7:0] ob;
    logic [2:0] obit;
    logic so, so_oe;
    logic rst_en, inprog;
    logic [1:0] kind, susf;
    logic pdn, lowp, blk;
    sfp_tmr_e tk;
    logic [19:0] tmr;
    logic fwd;
    logic [7:0] fopc;
    sfp_arr_out_s arr;
  } sfp_st_s;
endpackage

// ===== sfp_regs.svh
// Operation
// R1: Security read: opcode, 3 or 4 address bytes, one dummy byte, bits taken on rising SCK.
// R2: After the dummy byte, security data leaves on SO, one bit per falling SCK.
// R3: Byte address advances after each output byte; low ten bits wrap from last to zero.
// R4: Reset needs an enable-reset frame then a reset frame, in single or quad mode.
// R5: Accepted reset aborts work and clears all volatile state back to power-on values.
// R6: During reset recovery every incoming command is rejected.
// R7: Host should poll busy and suspend flags before issuing the reset pair.
// R8: Suspend is taken only during program or erase, busy set and no suspend flag.
// R9: Accepted suspend sets its flag at once and drops busy within the suspend time.
// R10: Program suspended: status write, security erase/program, erases and programs are refused.
// R11: Erase suspended: status write, security erase and erases refused; programs still pass.
// R12: Resume is taken only with a suspend flag set and busy clear.
// R13: Accepted resume clears the flag at once, sets busy within the bound, continues.
// R14: Power-down runs only if select rises right after opcode bit eight; entry after delay.
// R15: Power-down arriving while a cycle is busy is rejected; the cycle goes on.
// R16: In power-down only the release opcode and the reset pair are heard.
// R17: After a release frame, commands are accepted again only after the release time.
// R18: Host keeps select high during the whole release time.
// R19: ID read: release opcode, three dummy bytes, then ID MSB first, repeated until deselect.
// R20: Release or ID read arriving while busy is ignored; the cycle is untouched.
// R21: Address is 24 bits by default, 32 bits in four-byte mode.
// R22: Busy flag is one during a self-timed program or erase, zero after.
// R23: A frame ending before a full opcode byte is dropped and changes nothing.
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH
`define SFP_CLK_NS 20
`define SFP_RESUME_MAX_NS 200
`define SFP_ONE_BIT 6'h01
`define SFP_NIB 6'h04
`define SFP_OP_BITS 6'h08
`define SFP_ADDR3_BITS 6'h18
`define SFP_ADDR4_BITS 6'h20
`define SFP_DUMMY_BITS 6'h08
`define SFP_ID_DUMMY_BITS 6'h18
`define SFP_SEC_LAST 10'h3ff
`define SFP_SEC_FIRST 10'h000
`define SFP_KIND_PROG 2'h1
`define SFP_KIND_ERASE 2'h2
`define SFP_OP_SEC_RD 8'h48
`define SFP_OP_RST_EN 8'h66
`define SFP_OP_RST 8'h99
`define SFP_OP_SUS 8'h75
`define SFP_OP_RES 8'h7a
`define SFP_OP_PWRDN 8'hb9
`define SFP_OP_REL 8'hab
`define SFP_OP_WRSR 8'h01
`define SFP_OP_SEC_ER 8'h44
`define SFP_OP_SEC_PG 8'h42
`define SFP_OP_SE_A 8'h20
`define SFP_OP_SE_B 8'h21
`define SFP_OP_BK32_A 8'h52
`define SFP_OP_BK32_B 8'h5c
`define SFP_OP_BK64_A 8'hd8
`define SFP_OP_BK64_B 8'hdc
`define SFP_OP_CHIP_A 8'hc7
`define SFP_OP_CHIP_B 8'h60
`define SFP_OP_PG_A 8'h02
`define SFP_OP_PG_B 8'h12
`define SFP_OP_QPG_A 8'h32
`define SFP_OP_QPG_B 8'h34
`endif
